// [hdl/sfrb_register_bank.sv]
// sfrb_register_bank: bank-zero special register map of an 8-bit core
// assumes: hresetn is the power-on / brown-out reset, other_reset the rest
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sfrb_register_bank
   import sfrb_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // non power-up reset and its status bits
   input  wire logic        other_reset,
   input  wire logic        reset_to_flag,
   input  wire logic        reset_pd_flag,
   // core program counter control
   input  wire logic        pc_load,
   input  wire logic [7:0]  pc_load_low,
   input  wire logic        pc_step,
   output logic [12:0]      pc_value,
   // port pins and latches
   input  wire logic [5:0]  port_a_pins,
   input  wire logic [7:0]  port_b_pins,
   input  wire logic [7:0]  port_c_pins,
   input  wire logic [7:0]  port_d_pins,
   input  wire logic [2:0]  port_e_pins,
   output logic [5:0]       port_a_latch,
   output logic [7:0]       port_b_latch,
   output logic [7:0]       port_c_latch,
   output logic [7:0]       port_d_latch,
   output logic [2:0]       port_e_latch,
   // bank select seen by the core
   output logic             direct_bank_select
);

   // ==========================================================
   // local state and wiring
   sfrb_bank_state_t st_reg;
   sfrb_bank_state_t st_next;
   sfrb_bus_if       bus ();
   sfrb_target_t     direct_tgt;
   sfrb_target_t     indirect_tgt;
   sfrb_target_t     tgt;
   logic             ram_we;
   logic [7:0]       ram_rdata;
   logic [7:0]       pins_byte;

   // ==========================================================
   // address decode, shared by direct and indirect access
   function automatic sfrb_target_t decode(input logic [7:0] a);
      sfrb_target_t t;
      t = '0;
      if ((a[6:0] <= IDX_LAST[6:0]) && (!a[BANK_BIT] || mirrored(a[6:0])))
      begin
         t.is_sfr = 1'b1;
         t.idx    = a[4:0];
      end
      else if (!a[BANK_BIT] && (a[6:0] >= RAM_BASE[6:0]))
      begin
         t.is_ram   = 1'b1;
         t.ram_addr = a[6:0] - RAM_BASE[6:0];
      end
      return t;
   endfunction

   // ==========================================================
   // pin value of a port register, zero elsewhere
   always_comb
   begin
      unique case (tgt.idx)
         IDX_PORT_A[4:0]: pins_byte = {2'b00, port_a_pins};
         IDX_PORT_B[4:0]: pins_byte = port_b_pins;
         IDX_PORT_C[4:0]: pins_byte = port_c_pins;
         IDX_PORT_D[4:0]: pins_byte = port_d_pins;
         IDX_PORT_E[4:0]: pins_byte = {5'b00000, port_e_pins};
         default:         pins_byte = ZERO_BYTE;
      endcase
   end

   // ==========================================================
   // target selection
   always_comb
   begin
      direct_tgt   = decode({st_reg.sfr[IDX_STATUS[4:0]][STATUS_BANK_BIT], bus.addr});
      indirect_tgt = decode(st_reg.sfr[IDX_POINTER[4:0]]);
      tgt          = direct_tgt;
      if (direct_tgt.is_sfr && (direct_tgt.idx == IDX_INDIRECT_DATA[4:0]))
      begin
         tgt = indirect_tgt;
         // pointing back at the indirect location reaches nothing
         if (indirect_tgt.is_sfr && (indirect_tgt.idx == IDX_INDIRECT_DATA[4:0]))
            tgt.is_sfr = 1'b0;
      end
   end

   // ==========================================================
   // read path
   always_comb
   begin
      bus.rdata = ZERO_BYTE;
      if (tgt.is_ram)
      begin
         bus.rdata = ram_rdata;
      end
      else if (tgt.is_sfr)
      begin
         unique case (tgt.idx)
            IDX_PC_LOW[4:0]:
               bus.rdata = st_reg.pc[7:0];
            IDX_PORT_A[4:0], IDX_PORT_B[4:0], IDX_PORT_C[4:0],
            IDX_PORT_D[4:0], IDX_PORT_E[4:0]:
               bus.rdata = pins_byte;
            default:
               bus.rdata = st_reg.sfr[tgt.idx] & reg_mask(tgt.idx);
         endcase
      end
   end

   assign ram_we = bus.wr_en && tgt.is_ram;

   // ==========================================================
   // next state: bus writes, program counter, other resets
   always_comb
   begin
      st_next = st_reg;

      // core program counter moves
      if (pc_load)
      begin
         st_next.pc = {st_reg.sfr[IDX_PC_HOLD[4:0]][4:0], pc_load_low};
      end
      else if (pc_step)
      begin
         st_next.pc = st_reg.pc + PC_ONE;
      end

      // software write wins over the core in the same cycle
      if (bus.wr_en && tgt.is_sfr)
      begin
         unique case (tgt.idx)
            IDX_PC_LOW[4:0]:
            begin
               // upper byte only reachable through the holding register
               st_next.pc = {st_reg.sfr[IDX_PC_HOLD[4:0]][4:0], bus.wdata};
            end
            IDX_STATUS[4:0]:
            begin
               // time-out and power-down bits are read only
               st_next.sfr[IDX_STATUS[4:0]] =
                  (st_reg.sfr[IDX_STATUS[4:0]] & STATUS_RO_MASK)
                  | (bus.wdata & ~STATUS_RO_MASK);
            end
            IDX_RX_DATA[4:0]:
            begin
               // receive data is read only here
               st_next.sfr[IDX_RX_DATA[4:0]] = st_reg.sfr[IDX_RX_DATA[4:0]];
            end
            default:
            begin
               st_next.sfr[tgt.idx] = bus.wdata & reg_mask(tgt.idx);
            end
         endcase
      end

      // external pin or watchdog reset: hold the u bits, load time-out and power-down from the flags, clear the rest
      if (other_reset)
      begin
         for (int i = 0; i < SFR_COUNT; i++)
         begin
            st_next.sfr[i] = st_reg.sfr[i] & keep_mask(5'(i));
         end
         st_next.sfr[IDX_STATUS[4:0]][STATUS_TO_BIT] = reset_to_flag;
         st_next.sfr[IDX_STATUS[4:0]][STATUS_PD_BIT] = reset_pd_flag;
         st_next.pc = PC_RESET;
      end
   end

   // ==========================================================
   // state register, power-on / brown-out values
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg                       <= '0;
         st_reg.sfr[IDX_STATUS[4:0]]  <= STATUS_POR;
         st_reg.pc                    <= PC_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // bus front end and data memory
   sfrb_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .hrdata    (hrdata),
      .bus       (bus.front)
   );

   sfrb_data_ram u_ram (
      .hclk    (hclk),
      .hresetn (hresetn),
      .wr_en   (ram_we),
      .addr    (tgt.ram_addr),
      .wdata   (bus.wdata),
      .rdata   (ram_rdata)
   );

   // ==========================================================
   // outputs, all from flip-flops
   assign pc_value           = st_reg.pc;
   assign port_a_latch       = st_reg.sfr[IDX_PORT_A[4:0]][5:0];
   assign port_b_latch       = st_reg.sfr[IDX_PORT_B[4:0]];
   assign port_c_latch       = st_reg.sfr[IDX_PORT_C[4:0]];
   assign port_d_latch       = st_reg.sfr[IDX_PORT_D[4:0]];
   assign port_e_latch       = st_reg.sfr[IDX_PORT_E[4:0]][2:0];
   assign direct_bank_select = st_reg.sfr[IDX_STATUS[4:0]][STATUS_BANK_BIT];

endmodule // sfrb_register_bank
`default_nettype wire

// [hdl/sfrb_pkg.sv]
// sfrb_pkg: constants and types of the bank-zero special register map
// assumes: register index = byte address / 4 on the AHB-Lite bus
package sfrb_pkg;

   // ==========================================================
   // register indices
   localparam logic [7:0] IDX_INDIRECT_DATA = 8'h00;
   localparam logic [7:0] IDX_TIMER0        = 8'h01;
   localparam logic [7:0] IDX_PC_LOW        = 8'h02;
   localparam logic [7:0] IDX_STATUS        = 8'h03;
   localparam logic [7:0] IDX_POINTER       = 8'h04;
   localparam logic [7:0] IDX_PORT_A        = 8'h05;
   localparam logic [7:0] IDX_PORT_B        = 8'h06;
   localparam logic [7:0] IDX_PORT_C        = 8'h07;
   localparam logic [7:0] IDX_PORT_D        = 8'h08;
   localparam logic [7:0] IDX_PORT_E        = 8'h09;
   localparam logic [7:0] IDX_PC_HOLD       = 8'h0A;
   localparam logic [7:0] IDX_INT_CTRL      = 8'h0B;
   localparam logic [7:0] IDX_IRQ_FLAGS1    = 8'h0C;
   localparam logic [7:0] IDX_IRQ_FLAGS2    = 8'h0D;
   localparam logic [7:0] IDX_T1_CTRL       = 8'h10;
   localparam logic [7:0] IDX_RX_STATCTRL   = 8'h18;
   localparam logic [7:0] IDX_RX_DATA       = 8'h1A;
   localparam logic [7:0] IDX_T2_CTRL       = 8'h12;
   localparam logic [7:0] IDX_CC1_CTRL      = 8'h17;
   localparam logic [7:0] IDX_CC2_CTRL      = 8'h1D;
   localparam logic [7:0] IDX_LAST          = 8'h1D;
   localparam int         SFR_COUNT         = 30;

   // ==========================================================
   // address space
   localparam int         ADDR_LSB   = 2;
   localparam int         ADDR_MSB   = 8;
   localparam logic [7:0] RAM_BASE   = 8'h20;
   localparam int         RAM_DEPTH  = 96;
   localparam int         BANK_BIT   = 7;

   // ==========================================================
   // status fields and reset values
   localparam int         STATUS_BANK_BIT = 5;
   localparam int         STATUS_TO_BIT   = 4;
   localparam int         STATUS_PD_BIT   = 3;
   localparam logic [7:0] STATUS_RO_MASK  = 8'h18;
   localparam logic [7:0] STATUS_POR      = 8'h18;
   localparam logic [7:0] ZERO_BYTE       = 8'h00;
   localparam logic [7:0] FULL_MASK       = 8'hFF;
   localparam logic [12:0] PC_RESET      = 13'h0000;
   localparam logic [12:0] PC_ONE        = 13'h0001;

   // ==========================================================
   // types
   typedef struct packed {
      logic [SFR_COUNT-1:0][7:0] sfr;
      logic [12:0]               pc;
   } sfrb_bank_state_t;

   typedef struct packed {
      logic       is_sfr;
      logic       is_ram;
      logic [4:0] idx;
      logic [6:0] ram_addr;
   } sfrb_target_t;

   typedef enum logic [3:0] {
      FR_IDLE    = 4'b0001,
      FR_WRITE   = 4'b0010,
      FR_RD_WAIT = 4'b0100,
      FR_RD_DONE = 4'b1000
   } sfrb_front_state_t;

   typedef struct packed {
      sfrb_front_state_t state;
      logic [6:0]        addr;
      logic              bad;
      logic [31:0]       hrdata;
   } sfrb_front_reg_t;

   // ==========================================================
   // implemented bits of each register
   function automatic logic [7:0] reg_mask(input logic [4:0] idx);
      unique case (idx)
         IDX_PORT_A[4:0],
         IDX_T1_CTRL[4:0],
         IDX_CC1_CTRL[4:0],
         IDX_CC2_CTRL[4:0]:     reg_mask = 8'h3F;
         IDX_PORT_E[4:0]:       reg_mask = 8'h07;
         IDX_PC_HOLD[4:0]:      reg_mask = 8'h1F;
         IDX_IRQ_FLAGS2[4:0]:   reg_mask = 8'h01;
         IDX_T2_CTRL[4:0]:      reg_mask = 8'h7F;
         IDX_RX_STATCTRL[4:0]:  reg_mask = 8'hF7;
         default:               reg_mask = FULL_MASK;
      endcase
   endfunction

   // bits that survive a non power-up reset
   function automatic logic [7:0] keep_mask(input logic [4:0] idx);
      unique case (idx)
         IDX_TIMER0[4:0], IDX_POINTER[4:0], IDX_PORT_A[4:0],
         IDX_PORT_B[4:0], IDX_PORT_C[4:0], IDX_PORT_D[4:0],
         IDX_PORT_E[4:0], 5'h0E, 5'h0F, IDX_T1_CTRL[4:0],
         5'h13, 5'h15, 5'h16, 5'h1B, 5'h1C: keep_mask = FULL_MASK;
         IDX_STATUS[4:0]:                    keep_mask = 8'h07;
         IDX_INT_CTRL[4:0],
         IDX_RX_STATCTRL[4:0]:               keep_mask = 8'h01;
         default:                            keep_mask = ZERO_BYTE;
      endcase
   endfunction

   // registers seen from either bank
   function automatic logic mirrored(input logic [6:0] a);
      mirrored = (a == IDX_INDIRECT_DATA[6:0]) || (a == IDX_PC_LOW[6:0])
              || (a == IDX_STATUS[6:0]) || (a == IDX_POINTER[6:0])
              || (a == IDX_PC_HOLD[6:0]) || (a == IDX_INT_CTRL[6:0]);
   endfunction

endpackage

// [hdl/sfrb_bus_if.sv]
// sfrb_bus_if: word requests from the bus front end to the register bank
// assumes: one clock domain, wr_en is a one-cycle strobe
`timescale 1ns/10ps
`default_nettype none
interface sfrb_bus_if;
   logic       wr_en;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport front (output wr_en, output addr, output wdata, input rdata);
   modport bank  (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [hdl/sfrb_ahb_front.sv]
// sfrb_ahb_front: AHB-Lite slave front end, zero-wait writes, one-wait reads
// assumes: single word transfers, hready is this slave's hreadyout
`timescale 1ns/10ps
`default_nettype none
module sfrb_ahb_front
   import sfrb_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // register bank side
   sfrb_bus_if.front        bus
);
   sfrb_front_reg_t st_reg;
   sfrb_front_reg_t st_next;
   logic            accept;

   assign accept = hsel && htrans[1] && hready;

   // ==========================================================
   // state update
   always_comb
   begin
      st_next = st_reg;
      unique case (st_reg.state)
         FR_RD_WAIT:
         begin
            st_next.hrdata = st_reg.bad ? 32'h0000_0000 : {24'h00_0000, bus.rdata};
            st_next.state  = FR_RD_DONE;
         end
         FR_IDLE, FR_WRITE, FR_RD_DONE:
         begin
            st_next.state = FR_IDLE;
            if (accept)
            begin
               st_next.addr  = haddr[ADDR_MSB:ADDR_LSB];
               st_next.bad   = |haddr[31:ADDR_MSB+1];
               st_next.state = hwrite ? FR_WRITE : FR_RD_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st_reg <= '{state: FR_IDLE, addr: 7'h00, bad: 1'b0, hrdata: 32'h0000_0000};
      else
         st_reg <= st_next;
   end

   // ==========================================================
   // outputs
   assign hreadyout = (st_reg.state != FR_RD_WAIT);
   assign hresp     = 1'b0;
   assign hrdata    = st_reg.hrdata;
   assign bus.wr_en = (st_reg.state == FR_WRITE) && !st_reg.bad;
   assign bus.addr  = st_reg.addr;
   assign bus.wdata = hwdata[7:0];

endmodule // sfrb_ahb_front
`default_nettype wire

// [hdl/sfrb_data_ram.sv]
// sfrb_data_ram: general purpose data bytes behind the register map
// assumes: write strobe and address valid in the same cycle
`timescale 1ns/10ps
`default_nettype none
module sfrb_data_ram
   import sfrb_pkg::*;
(
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // access port
   input  wire logic       wr_en,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] wdata,
   output logic [7:0]      rdata
);
   logic [RAM_DEPTH-1:0][7:0] mem_reg;
   logic [RAM_DEPTH-1:0][7:0] mem_next;

   always_comb
   begin
      mem_next = mem_reg;
      if (wr_en)
         mem_next[addr] = wdata;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mem_reg <= '0;
      else
         mem_reg <= mem_next;
   end

   assign rdata = mem_reg[addr];

endmodule // sfrb_data_ram
`default_nettype wire

// [verif/sfrb_register_bank_chk.sv]
// sfrb_register_bank_chk: bus timing and program counter assertions
// assumes: bound to sfrb_register_bank, hready looped from hreadyout
`timescale 1ns/10ps
`default_nettype none
module sfrb_register_bank_chk
(
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   // core side
   input wire logic        other_reset,
   input wire logic        pc_load,
   input wire logic [7:0]  pc_load_low,
   input wire logic        pc_step,
   input wire logic [12:0] pc_value,
   input wire logic [7:0]  port_b_latch,
   input wire logic        direct_bank_select
);
   // ====================
   // data phase tracking
   logic       take;
   logic       quiet;
   logic       cause;
   logic       dp_wr_reg;
   logic       dp_hold_reg;
   logic [4:0] hold_reg;
   logic       live_reg;
   assign take  = hsel && htrans[1] && hready;
   assign quiet = !other_reset && !dp_wr_reg;
   assign cause = dp_wr_reg || other_reset;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_reg   <= 1'b0;
         dp_hold_reg <= 1'b0;
         hold_reg    <= 5'h00;
         live_reg    <= 1'b0;
      end
      else
      begin
         // history is only trusted from the second edge after release
         live_reg    <= 1'b1;
         dp_wr_reg   <= take && hwrite;
         dp_hold_reg <= take && hwrite && (haddr[31:2] == 30'h0000000A);
         if (other_reset)
            hold_reg <= 5'h00;
         else if (dp_hold_reg)
            hold_reg <= hwdata[4:0];
      end
   end
   // ====================
   // assertions
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn || !live_reg);
   sequence s_rd_take;
      take && !hwrite;
   endsequence
   sequence s_rd_answer;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_one_wait: assert property (s_rd_take |=> s_rd_answer)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (take && hwrite |=> hreadyout)
      else $error("write was stalled");
   a_rdata_only_done: assert property ($changed(hrdata) |-> !$past(hreadyout))
      else $error("read data changed outside a read");
   a_pc_load_value: assert property (
      quiet && pc_load |=> pc_value == {$past(hold_reg), $past(pc_load_low)})
      else $error("pc load value wrong");
   a_pc_step_incr: assert property (
      quiet && pc_step && !pc_load |=> pc_value == $past(pc_value) + 13'h0001)
      else $error("pc step wrong");
   a_pc_no_path: assert property (
      quiet && !pc_load && !pc_step |=> $stable(pc_value))
      else $error("pc changed with no cause");
   a_reset_pc_clear: assert property (other_reset |=> pc_value == 13'h0000)
      else $error("pc not cleared by other reset");
   a_bank_sel_cause: assert property ($changed(direct_bank_select) |-> $past(cause))
      else $error("bank select changed with no cause");
   a_latch_kept: assert property ($changed(port_b_latch) |-> $past(dp_wr_reg))
      else $error("port latch changed with no write");
endmodule // sfrb_register_bank_chk
`default_nettype wire

// [verif/sfrb_register_bank_tb.sv]
// sfrb_register_bank_tb: self-checking bench for the special register map
// assumes: hready looped from hreadyout, one 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
module sfrb_register_bank_tb
   import sfrb_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic        other_reset, to_f, pd_f, pc_load, pc_step, bank_sel;
   logic [1:0]  htrans;
   logic [2:0]  hsize, pins_e, lat_e;
   logic [5:0]  pins_a, lat_a;
   logic [7:0]  pins_b, pins_c, pins_d, lat_b, lat_c, lat_d, lo;
   logic [12:0] pc_value;
   logic [31:0] haddr, hwdata, hrdata, d, h, p;
   int          n_mismatch, samples_checked, seed, i;
   logic [7:0]  wi [10] = '{8'h0A, 8'h0C, 8'h0D, 8'h10, 8'h12, 8'h17, 8'h1D, 8'h0E, 8'h13, 8'h1B};
   logic [7:0]  wm [10] = '{8'h1F, 8'hFF, 8'h01, 8'h3F, 8'h7F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0]  ri [8] = '{8'h03, 8'h02, 8'h0A, 8'h0C, 8'h12, 8'h19, 8'h1A, 8'h0B};
   logic [7:0]  rv [8] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   sfrb_register_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .other_reset(other_reset),
      .reset_to_flag(to_f), .reset_pd_flag(pd_f), .pc_load(pc_load), .pc_load_low(lo),
      .pc_step(pc_step), .pc_value(pc_value), .port_a_pins(pins_a), .port_b_pins(pins_b),
      .port_c_pins(pins_c), .port_d_pins(pins_d), .port_e_pins(pins_e), .port_a_latch(lat_a),
      .port_b_latch(lat_b), .port_c_latch(lat_c), .port_d_latch(lat_d), .port_e_latch(lat_e),
      .direct_bank_select(bank_sel));

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   initial
   begin
      #3000000;
      n_mismatch++;
      test_done();
   end

   // ====================
   // bus and check tasks
   function automatic logic [31:0] fa(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_rdy(output logic [31:0] rd);
      logic r;
      int   n;
      n = 0;
      do
      begin
         @(negedge hclk);
         r = hreadyout;
         rd = hrdata;
         @(posedge hclk);
         n++;
         if (n > 20)
         begin
            n_mismatch++;
            test_done();
         end
      end
      while (r !== 1'b1);
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      wait_rdy(rd);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy(rd);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, a, wd, rd);
   endtask
   task automatic rc(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      check(rd, exp);
   endtask

   // ====================
   // scenarios
   initial
   begin
      seed = 32'h6801D9BB;
      {hresetn, hsel, hwrite, other_reset, to_f, pd_f, pc_load, pc_step} = 8'h00;
      {htrans, haddr, hwdata, lo} = '0;
      hsize = 3'b010;
      {pins_a, pins_b, pins_c, pins_d, pins_e} = '0;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (i = 0; i < 8; i++)
         rc(fa(ri[i]), {24'h0, rv[i]});
      for (i = 0; i < 10; i++)
      begin
         d = $random(seed);
         if (wi[i] == IDX_IRQ_FLAGS1)
            d[6] = 1'b0;
         wr(fa(wi[i]), d);
         rc(fa(wi[i]), {24'h0, d[7:0] & wm[i]});
      end
      wr(fa(IDX_RX_DATA), 32'hFF);
      rc(fa(IDX_RX_DATA), 32'h0);
      rc(fa(8'h1E), 32'h0);
      rc(32'h1000_0028, 32'h0);
      p = $random(seed);
      pins_b <= ~p[7:0];
      pins_e <= ~p[10:8];
      for (i = 0; i < 5; i++)
         wr(fa(IDX_PORT_A + i[7:0]), p);
      @(negedge hclk);
      check(lat_c, p[7:0]);
      @(posedge hclk);
      rc(fa(IDX_PORT_B), {24'h0, ~p[7:0]});
      rc(fa(IDX_PORT_E), {29'h0, ~p[10:8]});
      h = $random(seed);
      lo <= h[15:8];
      wr(fa(IDX_PC_HOLD), h);
      pc_load <= 1'b1;
      @(posedge hclk);
      pc_load <= 1'b0;
      pc_step <= 1'b1;
      @(negedge hclk);
      check(pc_value, {h[4:0], lo});
      @(posedge hclk);
      pc_step <= 1'b0;
      rc(fa(IDX_PC_LOW), {24'h0, lo + 8'h01});
      wr(fa(IDX_PC_LOW), 32'h0000_1F3C);
      @(negedge hclk);
      check(pc_value, {h[4:0], 8'h3C});
      @(posedge hclk);
      d = $random(seed);
      wr(fa(IDX_POINTER), 32'h25);
      wr(fa(IDX_INDIRECT_DATA), d);
      rc(fa(8'h25), {24'h0, d[7:0]});
      rc(fa(IDX_INDIRECT_DATA), {24'h0, d[7:0]});
      wr(fa(IDX_POINTER), 32'h0);
      rc(fa(IDX_INDIRECT_DATA), 32'h0);
      wr(fa(IDX_IRQ_FLAGS1), 32'h81);
      wr(fa(IDX_STATUS), 32'h20);
      @(negedge hclk);
      check(bank_sel, 1'b1);
      @(posedge hclk);
      rc(fa(IDX_STATUS), 32'h38);
      wr(fa(8'h0E), 32'h01);
      rc(fa(8'h0E), 32'h0);
      wr(fa(IDX_PC_HOLD), 32'h0B);
      wr(fa(IDX_IRQ_FLAGS1), 32'h3F);
      wr(fa(IDX_STATUS), 32'h00);
      rc(fa(IDX_PC_HOLD), 32'h0B);
      rc(fa(IDX_IRQ_FLAGS1), 32'h81);
      wr(fa(IDX_POINTER), 32'h5A);
      wr(fa(IDX_INT_CTRL), 32'hFF);
      wr(fa(IDX_STATUS), 32'h07);
      to_f <= 1'b1;
      other_reset <= 1'b1;
      @(posedge hclk);
      other_reset <= 1'b0;
      rc(fa(IDX_POINTER), 32'h5A);
      rc(fa(IDX_INT_CTRL), 32'h01);
      rc(fa(IDX_STATUS), 32'h17);
      rc(fa(IDX_PC_HOLD), 32'h0);
      rc(fa(IDX_T2_CTRL), 32'h0);
      rc(fa(8'h25), {24'h0, d[7:0]});
      check(lat_a, p[5:0]);
      check(lat_b, p[7:0]);
      check(lat_c, p[7:0]);
      check(lat_d, p[7:0]);
      check(lat_e, p[2:0]);
      check(hresp, 1'b0);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc(fa(IDX_STATUS), 32'h18);
      rc(fa(IDX_POINTER), 32'h0);
      test_done();
   end
endmodule // sfrb_register_bank_tb

bind sfrb_register_bank sfrb_register_bank_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .other_reset(other_reset),
   .pc_load(pc_load), .pc_load_low(pc_load_low), .pc_step(pc_step), .pc_value(pc_value),
   .port_b_latch(port_b_latch), .direct_bank_select(direct_bank_select));
`default_nettype wire
